// ---- ipc_top.sv ----
// ipc_top.sv: interrupt priority control, trap status and first flag register
//
// Operation
// RULE_01: status bits 7..5 hold the low three cpu level bits, 7 disables user.
// RULE_02: cpu level is top bit over low bits; top bit one blocks user interrupts.
// RULE_03: core control bit 3 reads one when cpu level exceeds seven.
// RULE_04: software may read and clear the top level bit, never set it.
// RULE_05: low level bits ignore software writes while nesting is off.
// RULE_06: control-one bit 15 one turns interrupt nesting off.
// RULE_07: control-one bit 6 records whether the math trap was a divide by zero.
// RULE_08: control-one bit 5 sets on a dma controller error trap.
// RULE_09: control-one bit 4 sets on any math error trap.
// RULE_10: control-one bit 3 sets on address trap, bit 2 on stack trap.
// RULE_11: control-one bit 1 sets on an oscillator failure trap.
// RULE_12: control-two bit 15 selects the alternate vector table.
// RULE_13: control-two bit 14 reads one while timed disable is active.
// RULE_14: control-two bits 4..0 pick falling (1) or rising (0) edge per input.
// RULE_15: flag bits 0..7: ext0, cap1, cmp1, tmr1, dma0, cap2, cmp2, tmr2.
// RULE_16: flag bits 8..14: tmr3, spi fault, spi event, uart rx/tx, conv1, dma1.
// RULE_17: a flag reads one once its request occurred and stays writable.
// RULE_18: unimplemented bits read zero and ignore writes.
// RULE_19: every implemented bit clears to zero at reset.
// RULE_20: sources set flags; only software clears them.
// RULE_21: each user source gets one of eight priority levels.
// RULE_22: forward a pending enabled request only above the cpu level.
// RULE_23: external edge is found from registered pin versus previous sample.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`default_nettype none
module ipc_top (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic osc_trap,
	input wire logic addr_trap,
	input wire logic stack_trap,
	input wire logic arith_trap,
	input wire logic divide_zero_trap,
	input wire logic dma_trap,
	input wire logic trap_taken,
	input wire logic core_level_load,
	input wire logic [3:0] core_level_val,
	input wire logic timed_disable_in,
	input wire logic [ipc_pkg::NUM_EXT-1:0] ext_pin,
	input wire logic capture1_req,
	input wire logic compare1_req,
	input wire logic timer1_req,
	input wire logic dma_ch0_done_req,
	input wire logic capture2_req,
	input wire logic compare2_req,
	input wire logic timer2_req,
	input wire logic timer3_req,
	input wire logic spi1_fault_req,
	input wire logic spi1_event_req,
	input wire logic uart1_rx_req,
	input wire logic uart1_tx_req,
	input wire logic conv1_done_req,
	input wire logic dma_ch1_done_req,
	output logic [3:0] cpu_level,
	output logic nesting_off,
	output logic alt_table_select,
	output logic [ipc_pkg::NUM_EXT-1:0] ext_edge,
	output logic irq_req,
	output logic [2:0] irq_level,
	output logic [3:0] irq_source
);
	import ipc_pkg::*;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] m);
		merge16 = (old & ~m) | (wd & m);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, write lands on the waitrequest-low edge
	ipc_bus_e bus_q;
	ipc_bus_e bus_d;
	logic wait_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_mux;
	wire logic bus_req = avs_read | avs_write;
	wire logic bus_start = (bus_q == BUS_IDLE) & bus_req;
	wire logic wr_en = (bus_q == BUS_DONE) & avs_write;
	wire logic [15:0] wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire logic [15:0] wd16 = avs_writedata[15:0];
	wire logic hit_status = wr_en & (avs_address == OFS_STATUS);
	wire logic hit_core = wr_en & (avs_address == OFS_CORE);
	wire logic hit_ctl1 = wr_en & (avs_address == OFS_CTL1);
	wire logic hit_ctl2 = wr_en & (avs_address == OFS_CTL2);
	wire logic hit_flags = wr_en & (avs_address == OFS_FLAGS0);
	wire logic hit_enable = wr_en & (avs_address == OFS_ENABLE0);
	wire logic hit_plo = wr_en & (avs_address == OFS_PRIO_LO);
	wire logic hit_phi = wr_en & (avs_address == OFS_PRIO_HI);

	always_comb begin
		case (bus_q)
			BUS_IDLE: bus_d = bus_req ? BUS_DONE : BUS_IDLE;
			BUS_DONE: bus_d = BUS_IDLE;
			default: bus_d = BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bus_q <= BUS_IDLE;
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			bus_q <= bus_d;
			wait_q <= ~bus_start;
			if (bus_start) begin
				rdata_q <= rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// cpu level: low bits in status, top bit in core control
	logic [15:0] c1_q;
	// declared ahead: the software level gate needs it
	wire logic nest_off_w = c1_q[C1_NEST_BIT]; // RULE_06
	logic [2:0] lvl_q;
	logic top_q;
	wire logic [3:0] cur_level = {top_q, lvl_q}; // RULE_02
	wire logic sw_lvl_we = hit_status & avs_byteenable[0] & ~nest_off_w; // RULE_05
	wire logic [2:0] lvl_d = core_level_load ? core_level_val[2:0] :
		sw_lvl_we ? wd16[ST_LVL_LSB +: 3] : lvl_q; // RULE_01
	// software can only clear; trap entry and the core itself may raise it
	wire logic top_clr = hit_core & avs_byteenable[0] & ~wd16[CC_TOP_BIT]; // RULE_04
	wire logic top_d = trap_taken | (core_level_load ? core_level_val[3] :
		(top_q & ~top_clr)); // RULE_04

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			lvl_q <= RST_REG[2:0]; // RULE_19
			top_q <= RST_REG[0];
		end else begin
			lvl_q <= lvl_d;
			top_q <= top_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control one: nesting off and sticky trap status
	logic [15:0] trap_set;
	always_comb begin
		trap_set = 16'h0000;
		trap_set[C1_DMA_BIT] = dma_trap; // RULE_08
		trap_set[C1_MATH_BIT] = arith_trap; // RULE_09
		trap_set[C1_ADDR_BIT] = addr_trap; // RULE_10
		trap_set[C1_STK_BIT] = stack_trap; // RULE_10
		trap_set[C1_OSC_BIT] = osc_trap; // RULE_11
	end
	wire logic [15:0] c1_sw = hit_ctl1 ? merge16(c1_q, wd16, wmask & C1_MASK) : c1_q;
	logic [15:0] c1_d;
	always_comb begin
		c1_d = c1_sw | trap_set;
		// a math trap writes the cause, set or cleared, over any software write
		if (arith_trap) begin
			c1_d[C1_DIV0_BIT] = divide_zero_trap; // RULE_07
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control two: table select, polarity, timed disable status
	logic [15:0] c2_q;
	logic tdis_q;
	wire logic [15:0] c2_d = hit_ctl2 ? merge16(c2_q, wd16, wmask & C2_RW_MASK) : c2_q;
	wire logic [NUM_EXT-1:0] pol_w = c2_q[C2_POL_LSB +: NUM_EXT];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			c1_q <= RST_REG; // RULE_19
			c2_q <= RST_REG;
			tdis_q <= RST_REG[0];
		end else begin
			c1_q <= c1_d;
			c2_q <= c2_d;
			tdis_q <= timed_disable_in; // RULE_13
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// external pins; a pin high through reset shows a rising edge after it
	logic [NUM_EXT-1:0] ext_smp_q;
	logic [NUM_EXT-1:0] ext_prev_q;
	logic [NUM_EXT-1:0] ext_edge_q;
	wire logic [NUM_EXT-1:0] edge_w = (pol_w & ext_prev_q & ~ext_smp_q) |
		(~pol_w & ~ext_prev_q & ext_smp_q); // RULE_14 RULE_23

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ext_smp_q <= '0;
			ext_prev_q <= '0;
			ext_edge_q <= '0;
		end else begin
			ext_smp_q <= ext_pin; // RULE_23
			ext_prev_q <= ext_smp_q;
			ext_edge_q <= edge_w;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// first flag register, enables and priorities
	logic [15:0] fl_q;
	logic [15:0] en_q;
	logic [15:0] flag_set;
	always_comb begin
		flag_set = 16'h0000;
		flag_set[SRC_EXT0] = edge_w[0]; // RULE_15
		flag_set[SRC_CAP1] = capture1_req;
		flag_set[SRC_CMP1] = compare1_req;
		flag_set[SRC_TMR1] = timer1_req;
		flag_set[SRC_DMA0] = dma_ch0_done_req;
		flag_set[SRC_CAP2] = capture2_req;
		flag_set[SRC_CMP2] = compare2_req;
		flag_set[SRC_TMR2] = timer2_req;
		flag_set[SRC_TMR3] = timer3_req; // RULE_16
		flag_set[SRC_SPIF] = spi1_fault_req;
		flag_set[SRC_SPIE] = spi1_event_req;
		flag_set[SRC_URX1] = uart1_rx_req;
		flag_set[SRC_UTX1] = uart1_tx_req;
		flag_set[SRC_CNV1] = conv1_done_req;
		flag_set[SRC_DMA1] = dma_ch1_done_req;
	end
	// set wins over a clearing write in the same cycle
	wire logic [15:0] fl_d = (hit_flags ? merge16(fl_q, wd16, wmask & FLAGS0_MASK) : fl_q)
		| flag_set; // RULE_17 RULE_20
	wire logic [15:0] en_d = hit_enable ? merge16(en_q, wd16, wmask & FLAGS0_MASK) : en_q;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			fl_q <= RST_REG; // RULE_19
			en_q <= RST_REG;
		end else begin
			fl_q <= fl_d;
			en_q <= en_d;
		end
	end

	logic [2:0] prio_q [NUM_SRC];
	logic [63:0] prio_rd;
	genvar k;
	generate
		for (k = 0; k < NUM_SRC; k++) begin : g_prio
			localparam int SLOT = k % PRIO_PER_REG;
			wire logic hit_p = (k < PRIO_PER_REG) ? hit_plo : hit_phi;
			wire logic we_p = hit_p & avs_byteenable[SLOT / 2];
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					prio_q[k] <= RST_REG[2:0];
				end else if (we_p) begin
					prio_q[k] <= avs_writedata[SLOT*PRIO_FLD_W +: 3]; // RULE_21
				end
			end
			assign prio_rd[k*PRIO_FLD_W +: PRIO_FLD_W] = {1'b0, prio_q[k]};
		end
	endgenerate
	assign prio_rd[63:NUM_SRC*PRIO_FLD_W] = '0;

	////////////////////////////////////////////////////////////////////////////
	// arbitration: highest priority above cpu level, lowest index on a tie
	logic best_v;
	logic [2:0] best_p;
	logic [3:0] best_i;
	always_comb begin
		best_v = 1'b0;
		best_p = 3'h0;
		best_i = 4'h0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (fl_q[i] & en_q[i] & ({1'b0, prio_q[i]} > cur_level) & ~top_q &
				(~best_v | (prio_q[i] > best_p))) begin // RULE_22 RULE_02
				best_v = 1'b1;
				best_p = prio_q[i];
				best_i = 4'(i);
			end
		end
	end

	logic irq_q;
	logic [2:0] irq_lvl_q;
	logic [3:0] irq_src_q;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_q <= 1'b0;
			irq_lvl_q <= 3'h0;
			irq_src_q <= 4'h0;
		end else begin
			irq_q <= best_v;
			irq_lvl_q <= best_p;
			irq_src_q <= best_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux; everything not implemented reads as zero
	wire logic [15:0] rd_status = {8'h00, lvl_q, 5'h00}; // RULE_01
	wire logic [15:0] rd_core = {12'h000, (cur_level > 4'h7), 3'h0}; // RULE_03
	wire logic [15:0] rd_ctl2 = c2_q | {1'b0, tdis_q, 14'h0000}; // RULE_13
	assign rd_mux =
		(avs_address == OFS_STATUS) ? {16'h0000, rd_status} :
		(avs_address == OFS_CORE) ? {16'h0000, rd_core} :
		(avs_address == OFS_CTL1) ? {16'h0000, c1_q} :
		(avs_address == OFS_CTL2) ? {16'h0000, rd_ctl2} :
		(avs_address == OFS_FLAGS0) ? {16'h0000, fl_q} :
		(avs_address == OFS_ENABLE0) ? {16'h0000, en_q} :
		(avs_address == OFS_PRIO_LO) ? prio_rd[31:0] :
		(avs_address == OFS_PRIO_HI) ? prio_rd[63:32] : 32'h0000_0000; // RULE_18

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign cpu_level = cur_level;
	assign nesting_off = c1_q[C1_NEST_BIT]; // RULE_06
	assign alt_table_select = c2_q[C2_ALT_BIT]; // RULE_12
	assign ext_edge = ext_edge_q;
	assign irq_req = irq_q;
	assign irq_level = irq_lvl_q;
	assign irq_source = irq_src_q;

	////////////////////////////////////////////////////////////////////////////
	// checks
	top_no_set_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_04
		(hit_core & wd16[CC_TOP_BIT] & ~top_q & ~trap_taken & ~core_level_load)
		|=> ~top_q) else $error("top level bit set by software");
	level_ro_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_05
		(hit_status & nest_off_w & ~core_level_load) |=> $stable(lvl_q))
		else $error("level changed while nesting off");
	level_wr_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_01
		(hit_status & avs_byteenable[0] & ~nest_off_w & ~core_level_load)
		|=> (lvl_q == $past(wd16[7:5]))) else $error("level write lost");
	top_blocks_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_02
		top_q |=> ~irq_q) else $error("request forwarded above level seven");
	flag_sticky_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_20
		~hit_flags |=> (($past(fl_q) & ~fl_q) == 16'h0000))
		else $error("flag cleared by hardware");
	flag_set_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_17
		capture1_req |=> fl_q[SRC_CAP1]) else $error("request did not set flag");
	div0_cause_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_07
		arith_trap |=> (c1_q[C1_DIV0_BIT] == $past(divide_zero_trap)) & c1_q[C1_MATH_BIT])
		else $error("math trap cause wrong");
	ext_pol_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_14
		(ext_smp_q[0] & ~ext_prev_q[0] & ~pol_w[0]) |=> ext_edge_q[0] & fl_q[SRC_EXT0])
		else $error("rising edge missed");
	irq_above_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_22
		irq_q |-> ({1'b0, irq_lvl_q} > $past(cur_level)))
		else $error("request not above cpu level");
	core_rd_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_18
		(bus_start & (avs_address == OFS_CORE)) |=> (rdata_q[31:4] == 28'h0) &
		(rdata_q[2:0] == 3'h0) & (rdata_q[3] == $past(top_q)))
		else $error("core control read wrong");
	bus_ans_a: assert property (@(posedge clk_sys) disable iff (srst)
		bus_start |=> ~wait_q ##1 wait_q) else $error("bus answer timing wrong");
	set_vs_clr_c: cover property (@(posedge clk_sys) disable iff (srst)
		hit_flags & capture1_req & ~wd16[SRC_CAP1]);
	trap_c: cover property (@(posedge clk_sys) disable iff (srst) trap_taken ##1 top_q);
	irq_c: cover property (@(posedge clk_sys) disable iff (srst) ~irq_q ##1 irq_q);
	trap_sticky_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_10
		~hit_ctl1 |=> (($past(c1_q) & ~c1_q & 16'h003e) == 16'h0000))
		else $error("trap status cleared by hardware");
	edge_fall_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_14
		(ext_prev_q[0] & ~ext_smp_q[0] & pol_w[0]) |=> ext_edge_q[0] & fl_q[SRC_EXT0])
		else $error("falling edge missed");
	timed_rd_a: assert property (@(posedge clk_sys) disable iff (srst) // RULE_13
		(bus_start & (avs_address == OFS_CTL2)) |=> (rdata_q[C2_TDIS_BIT] == $past(tdis_q)))
		else $error("timed disable status read wrong");
	div0_c: cover property (@(posedge clk_sys) disable iff (srst)
		arith_trap & divide_zero_trap);
	ext_fall_c: cover property (@(posedge clk_sys) disable iff (srst)
		ext_edge_q[0] & pol_w[0]);
endmodule // ipc_top
`default_nettype wire

// ---- ipc_pkg.sv ----
// ipc_pkg.sv: constants and types for the interrupt priority control block
`default_nettype none
package ipc_pkg;
	localparam int NUM_SRC = 15;
	localparam int NUM_EXT = 5;
	// register byte offsets, one 32-bit word each
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CORE = 8'h04;
	localparam logic [7:0] OFS_CTL1 = 8'h08;
	localparam logic [7:0] OFS_CTL2 = 8'h0c;
	localparam logic [7:0] OFS_FLAGS0 = 8'h10;
	localparam logic [7:0] OFS_ENABLE0 = 8'h14;
	localparam logic [7:0] OFS_PRIO_LO = 8'h18;
	localparam logic [7:0] OFS_PRIO_HI = 8'h1c;
	// field positions
	localparam int ST_LVL_LSB = 5;
	localparam int CC_TOP_BIT = 3;
	localparam int C1_NEST_BIT = 15;
	localparam int C1_DIV0_BIT = 6;
	localparam int C1_DMA_BIT = 5;
	localparam int C1_MATH_BIT = 4;
	localparam int C1_ADDR_BIT = 3;
	localparam int C1_STK_BIT = 2;
	localparam int C1_OSC_BIT = 1;
	localparam int C2_ALT_BIT = 15;
	localparam int C2_TDIS_BIT = 14;
	localparam int C2_POL_LSB = 0;
	localparam int PRIO_FLD_W = 4;
	localparam int PRIO_PER_REG = 8;
	// source positions in the first flag register
	localparam int SRC_EXT0 = 0;
	localparam int SRC_CAP1 = 1;
	localparam int SRC_CMP1 = 2;
	localparam int SRC_TMR1 = 3;
	localparam int SRC_DMA0 = 4;
	localparam int SRC_CAP2 = 5;
	localparam int SRC_CMP2 = 6;
	localparam int SRC_TMR2 = 7;
	localparam int SRC_TMR3 = 8;
	localparam int SRC_SPIF = 9;
	localparam int SRC_SPIE = 10;
	localparam int SRC_URX1 = 11;
	localparam int SRC_UTX1 = 12;
	localparam int SRC_CNV1 = 13;
	localparam int SRC_DMA1 = 14;
	// implemented bits and reset value
	localparam logic [15:0] C1_MASK = 16'h807e;
	localparam logic [15:0] C2_RW_MASK = 16'h801f;
	localparam logic [15:0] FLAGS0_MASK = 16'h7fff;
	localparam logic [15:0] RST_REG = 16'h0000;
	typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_DONE = 2'b10} ipc_bus_e;
endpackage
`default_nettype wire

// ---- ipc_peer.sv ----
// ipc_peer.sv: model of the cpu core and the peripheral request sources
`default_nettype none
module ipc_peer (
	input wire logic clk_sys,
	output logic [20:0] pulse,
	output logic div0_lvl,
	output logic tdis_lvl,
	output logic [3:0] lvl_val,
	output logic [4:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		pulse = 21'h000000;
		div0_lvl = 1'b0;
		tdis_lvl = 1'b0;
		lvl_val = 4'h0;
		pins = 5'h00;
	end
	// one cycle only, then silent: the flag has to remember it
	task automatic fire(input int idx);
		@(posedge clk_sys);
		pulse <= 21'h000001 << idx;
		@(posedge clk_sys);
		pulse <= 21'h000000;
	endtask
	// levels held by the core and the pins until the next call
	task automatic set_levels(input logic div0, input logic tdis, input logic [3:0] lv,
		input logic [4:0] pn);
		div0_lvl <= div0;
		tdis_lvl <= tdis;
		lvl_val <= lv;
		pins <= pn;
	endtask
endmodule // ipc_peer
`default_nettype wire

// ---- ipc_top_tb_top.sv ----
// ipc_top_tb_top.sv: self-checking bench for the interrupt priority control block
`default_nettype none
module ipc_top_tb_top;
	import ipc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [20:0] pulse;
	logic div0_lvl, tdis_lvl, nesting_off, alt_table_select, irq_req;
	logic [3:0] lvl_val, cpu_level, irq_source;
	logic [4:0] pins, ext_edge;
	logic [2:0] irq_level;
	logic [31:0] rq;
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	int edge_cnt = 0;
	logic [15:0] trap_bit [5] = '{16'h0002, 16'h0008, 16'h0004, 16'h0010, 16'h0020};
	always #2.5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////
	ipc_peer peer (.clk_sys(clk_sys), .pulse(pulse), .div0_lvl(div0_lvl),
		.tdis_lvl(tdis_lvl), .lvl_val(lvl_val), .pins(pins));
	ipc_top DUT (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .osc_trap(pulse[0]), .addr_trap(pulse[1]),
		.stack_trap(pulse[2]), .arith_trap(pulse[3]), .divide_zero_trap(div0_lvl),
		.dma_trap(pulse[4]), .trap_taken(pulse[5]), .core_level_load(pulse[6]),
		.core_level_val(lvl_val), .timed_disable_in(tdis_lvl), .ext_pin(pins),
		.capture1_req(pulse[7]), .compare1_req(pulse[8]), .timer1_req(pulse[9]),
		.dma_ch0_done_req(pulse[10]), .capture2_req(pulse[11]), .compare2_req(pulse[12]),
		.timer2_req(pulse[13]), .timer3_req(pulse[14]), .spi1_fault_req(pulse[15]),
		.spi1_event_req(pulse[16]), .uart1_rx_req(pulse[17]), .uart1_tx_req(pulse[18]),
		.conv1_done_req(pulse[19]), .dma_ch1_done_req(pulse[20]), .cpu_level(cpu_level),
		.nesting_off(nesting_off), .alt_table_select(alt_table_select),
		.ext_edge(ext_edge), .irq_req(irq_req), .irq_level(irq_level),
		.irq_source(irq_source));
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ext_edge is a one-cycle pulse, so it is counted rather than sampled
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		edge_cnt <= edge_cnt + $countones(ext_edge);
		if (cyc == 20000) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// opens with an edge so a strobe dropped by the last access is never re-raised at once
	// a slave that never answers is caught by the cycle ceiling above
	task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= is_wr;
		avs_read <= !is_wr;
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		rq = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg_%h", a), e, rq[15:0]);
		chk($sformatf("upper_%h", a), 16'h0000, rq[31:16]);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		for (int i = 0; i < 8; i++) rc(8'(i * 4), 16'h0000);
		rc(8'h40, 16'h0000);
		$display("test reset done");
		wr(OFS_STATUS, 32'hffffffff);
		rc(OFS_STATUS, 16'h00e0);
		chk("cpu_level", 16'h0007, 16'(cpu_level));
		wr(OFS_CORE, 32'hffffffff);
		rc(OFS_CORE, 16'h0000);
		peer.fire(5);
		rc(OFS_CORE, 16'h0008);
		chk("cpu_level", 16'h000f, 16'(cpu_level));
		wr(OFS_CORE, 32'h0);
		rc(OFS_CORE, 16'h0000);
		$display("test level done");
		wr(OFS_CTL1, 32'hffffffff);
		rc(OFS_CTL1, 16'h807e);
		chk("nesting_off", 16'h0001, 16'(nesting_off));
		wr(OFS_STATUS, 32'h0);
		rc(OFS_STATUS, 16'h00e0);
		peer.set_levels(1'b0, 1'b0, 4'h3, 5'h00);
		peer.fire(6);
		rc(OFS_STATUS, 16'h0060);
		wr(OFS_CTL1, 32'h0);
		wr(OFS_STATUS, 32'h0);
		rc(OFS_STATUS, 16'h0000);
		$display("test nesting done");
		for (int i = 0; i < 5; i++) begin
			peer.fire(i);
			rc(OFS_CTL1, trap_bit[i]);
			wr(OFS_CTL1, 32'h0);
		end
		peer.set_levels(1'b1, 1'b0, 4'h0, 5'h00);
		peer.fire(3);
		rc(OFS_CTL1, 16'h0050);
		peer.set_levels(1'b0, 1'b0, 4'h0, 5'h00);
		peer.fire(3);
		rc(OFS_CTL1, 16'h0010);
		wr(OFS_CTL1, 32'h0);
		$display("test traps done");
		wr(OFS_CTL2, 32'hffffffff);
		rc(OFS_CTL2, 16'h801f);
		chk("alt_table_select", 16'h0001, 16'(alt_table_select));
		peer.set_levels(1'b0, 1'b1, 4'h0, 5'h00);
		rc(OFS_CTL2, 16'hc01f);
		wr(OFS_CTL2, 32'h0);
		rc(OFS_CTL2, 16'h4000);
		chk("alt_table_select", 16'h0000, 16'(alt_table_select));
		peer.set_levels(1'b0, 1'b0, 4'h0, 5'h00);
		rc(OFS_CTL2, 16'h0000);
		avs_byteenable <= 4'h1;
		wr(OFS_CTL2, 32'hffffffff);
		rc(OFS_CTL2, 16'h001f);
		chk("alt_table_select", 16'h0000, 16'(alt_table_select));
		avs_byteenable <= 4'h2;
		wr(OFS_CTL2, 32'hffffffff);
		rc(OFS_CTL2, 16'h801f);
		avs_byteenable <= 4'hf;
		wr(OFS_CTL2, 32'h0);
		$display("test control two done");
		for (int k = 1; k < 15; k++) begin
			peer.fire(6 + k);
			rc(OFS_FLAGS0, 16'h0001 << k);
			wr(OFS_FLAGS0, 32'h0);
		end
		wr(OFS_FLAGS0, 32'hffffffff);
		rc(OFS_FLAGS0, 16'h7fff);
		wr(OFS_FLAGS0, 32'h0);
		$display("test flags done");
		peer.set_levels(1'b0, 1'b0, 4'h0, 5'h1f);
		repeat (4) @(posedge clk_sys);
		chk("edge_cnt", 16'd5, 16'(edge_cnt));
		rc(OFS_FLAGS0, 16'h0001);
		wr(OFS_FLAGS0, 32'h0);
		wr(OFS_CTL2, 32'h0000001f);
		peer.set_levels(1'b0, 1'b0, 4'h0, 5'h00);
		repeat (4) @(posedge clk_sys);
		chk("edge_cnt", 16'd10, 16'(edge_cnt));
		rc(OFS_FLAGS0, 16'h0001);
		wr(OFS_FLAGS0, 32'h0);
		peer.set_levels(1'b0, 1'b0, 4'h0, 5'h1f);
		repeat (4) @(posedge clk_sys);
		chk("edge_cnt", 16'd10, 16'(edge_cnt));
		rc(OFS_FLAGS0, 16'h0000);
		$display("test external done");
		wr(OFS_ENABLE0, 32'h00000002);
		wr(OFS_PRIO_LO, 32'h00000050);
		wr(OFS_STATUS, 32'h00000080);
		peer.fire(7);
		repeat (2) @(posedge clk_sys);
		chk("irq_req", 16'h0001, 16'(irq_req));
		chk("irq_level", 16'h0005, 16'(irq_level));
		chk("irq_source", 16'h0001, 16'(irq_source));
		wr(OFS_STATUS, 32'h000000a0);
		repeat (2) @(posedge clk_sys);
		chk("irq_req", 16'h0000, 16'(irq_req));
		wr(OFS_STATUS, 32'h00000080);
		peer.fire(5);
		repeat (2) @(posedge clk_sys);
		chk("irq_req", 16'h0000, 16'(irq_req));
		$display("test forwarding done");
		report_and_stop();
	end
endmodule // ipc_top_tb_top
`default_nettype wire
